// File: common/dwr_pkg.sv
`default_nettype none
package dwr_pkg;
  localparam int unsigned CHANNELS          = 2;
  localparam int unsigned WIPER_WIDTH       = 8;
  localparam int unsigned TAPS              = 256;
  localparam logic [7:0]  WIPER_RESET       = 8'h80;
  localparam logic [7:0]  STORE_RESET       = 8'h80;
  localparam logic [7:0]  REG_POS0          = 8'h00;
  localparam logic [7:0]  REG_POS1          = 8'h01;
  localparam logic [7:0]  REG_ACCESS        = 8'h10;
  localparam logic [7:0]  PTR_WRAP          = 8'h0f;
  localparam int unsigned ACC_VOLATILE_BIT  = 7;
  localparam int unsigned ACC_SHDN_BIT      = 6;
  localparam int unsigned ACC_PENDING_BIT   = 5;
  localparam logic        ACC_VOLATILE_RST  = 1'b0;
  localparam logic        ACC_SHDN_RST      = 1'b1;
  localparam logic [4:0]  ID_PREFIX_DEFAULT = 5'h0a;
  localparam int unsigned CLOCK_MHZ         = 100;
  localparam int unsigned NV_PROGRAM_MS     = 12;
  localparam int unsigned NV_PROGRAM_MAX_MS = 20;
  localparam int unsigned NV_PROGRAM_CYCLES = NV_PROGRAM_MS * 1000 * CLOCK_MHZ;
  localparam int unsigned POWERUP_CYCLES    = 16;
endpackage
`default_nettype wire

// File: rtl/dwr_tap_switch.sv
`default_nettype none
// make-before-break tap selector: new tap closes, then old tap opens
module dwr_tap_switch #(
  parameter int unsigned TAPS = 256
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic [7:0]        code,
  output logic      [TAPS-1:0]   tap_closed
);
  typedef struct packed {
    logic [7:0]      old_code;
    logic            overlap;
    logic [TAPS-1:0] taps;
  } dwr_sw_type;
  dwr_sw_type st;
  dwr_sw_type next_st;

  always_comb
  begin
    next_st = st;
    if (code != st.old_code)
    begin
      next_st.taps[code] = 1'b1;
      next_st.overlap    = 1'b1;
      next_st.old_code   = code;
    end
    else if (st.overlap)
    begin
      next_st.taps    = '0;
      next_st.taps[code] = 1'b1;
      next_st.overlap = 1'b0;
    end
    if (reset)
    begin
      next_st          = '0;
      next_st.old_code = dwr_pkg::WIPER_RESET;
      next_st.taps[dwr_pkg::WIPER_RESET] = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    st <= next_st;
  end

  assign tap_closed = st.taps;
endmodule
`default_nettype wire

// File: rtl/dwr_wiper_ctrl.sv
`default_nettype none
// Functional notes
// - two channels, each with a wiper register and a retained initial store.
// - wiper registers are 8 bits; code 00h selects the tap at low end.
// - code ffh selects the tap nearest the high terminal.
// - tap index rises one for one with the code, 0 to 255.
// - at power-up wipers are forced to mid-scale 80h first.
// - after supply settles, wipers load from their initial stores.
// - initial store keeps its value across power loss.
// - received bits are sampled on rising scl edges.
// - transmitted bits change only after falling scl edges.
// - sda is open drain: pull low or release, never drive high.
// - two strap inputs give the low two bits of the slave address.
// - the device answers only when address bits match the straps.
// - stop after a store write starts a self-timed program cycle.
// - on a code change the new tap closes before the old opens.
// - program cycle ends within 20 ms, typically 12 ms.
// - volatile-select bit routes addresses 0,1 to wiper or store; resets clear.
// - writing an initial store also writes the matching wiper.
// - while program pending, flag reads set; wiper and control writes ignored.
module dwr_wiper_ctrl #(
  parameter int unsigned     NV_CYCLES = dwr_pkg::NV_PROGRAM_CYCLES,
  parameter logic [4:0]      ID_PREFIX = dwr_pkg::ID_PREFIX_DEFAULT // arbitrary
) (
  input  wire logic          CLOCK,
  input  wire logic          RESET,
  input  wire logic          SCL,
  input  wire logic          SDA_IN,
  output logic               SDA_OUT,
  output logic               SDA_OE_N,
  input  wire logic          ADDR_STRAP_HIGH,
  input  wire logic          ADDR_STRAP_LOW,
  output logic [7:0]         WIPER_POSITION_0,
  output logic [7:0]         WIPER_POSITION_1,
  output logic [255:0]       TAP_CLOSED_0,
  output logic [255:0]       TAP_CLOSED_1,
  output logic               SHUTDOWN_N,
  output logic               NV_WRITE_PENDING
);
  // ------------------------------------------------------------------
  // link side (scl domain): serial slave, owns nothing of the register set
  // ------------------------------------------------------------------
  typedef enum logic [5:0] {
    L_IDLE = 6'b000001,
    L_ID   = 6'b000010,
    L_ADDR = 6'b000100,
    L_WDAT = 6'b001000,
    L_RDAT = 6'b010000,
    L_RACK = 6'b100000
  } dwr_link_type;

  typedef struct packed {
    dwr_link_type state;
    logic [3:0]   bit_cnt;
    logic [7:0]   shift;
    logic [7:0]   pointer;
    logic [7:0]   wr_data;
    logic [7:0]   wr_addr;
    logic         wr_toggle;
    logic         ack;
    logic         drive;
  } dwr_rise_type;

  typedef struct packed {
    logic       sda_low;
  } dwr_fall_type;

  dwr_rise_type ls;
  dwr_rise_type next_ls;
  dwr_fall_type fs;
  dwr_fall_type next_fs;
  logic         start_seen;
  logic         start_clr;
  logic         stop_toggle;
  logic [7:0]   rd_value;
  logic [7:0]   rx_byte;
  logic         sync_strap_high;
  logic         sync_strap_low;

  // start and stop are sda edges while scl is high
  always_ff @(negedge SDA_IN or posedge start_clr)
  begin
    if (start_clr)
      start_seen <= 1'b0;
    else if (SCL)
      start_seen <= 1'b1;
  end

  always_ff @(posedge SDA_IN)
  begin
    if (RESET)
      stop_toggle <= 1'b0;
    else if (SCL)
      stop_toggle <= !stop_toggle;
  end

  // start is consumed once the first id bit has been taken
  assign start_clr = RESET || (ls.state == L_ID && ls.bit_cnt == 4'd1);
  assign rx_byte   = {ls.shift[6:0], SDA_IN};

  // rd_value: register image registered in the CLOCK domain below, taken by the link side with no sync stage
  always_comb
  begin
    next_ls = ls;
    if (start_seen && ls.state != L_ID)
    begin
      next_ls.state   = L_ID;
      next_ls.bit_cnt = 4'd1;
      next_ls.shift   = {7'h00, SDA_IN};
      next_ls.ack     = 1'b0;
      next_ls.drive   = 1'b0;
    end
    else
    begin
      unique case (ls.state)
        L_IDLE:
        begin
          next_ls.ack   = 1'b0;
          next_ls.drive = 1'b0;
        end
        L_ID, L_ADDR, L_WDAT:
        begin
          next_ls.ack = 1'b0;
          if (ls.bit_cnt < 4'd7)
          begin
            next_ls.shift   = rx_byte;
            next_ls.bit_cnt = ls.bit_cnt + 4'd1;
          end
          else if (ls.bit_cnt == 4'd8)
            next_ls.bit_cnt = 4'd0;
          else
          begin
            // eighth bit: decide now so the ack stands in the ninth slot
            next_ls.shift   = rx_byte;
            next_ls.bit_cnt = 4'd8;
            next_ls.ack     = 1'b1;
            if (ls.state == L_ID)
            begin
              if (rx_byte[7:3] == ID_PREFIX &&
                  rx_byte[2] == sync_strap_high &&
                  rx_byte[1] == sync_strap_low)
                next_ls.state = rx_byte[0] ? L_RDAT : L_ADDR;
              else
              begin
                next_ls.state = L_IDLE;
                next_ls.ack   = 1'b0;
              end
              next_ls.drive = 1'b0;
              if (rx_byte[0])
                next_ls.shift = rd_value;
            end
            else if (ls.state == L_ADDR)
            begin
              next_ls.pointer = rx_byte;
              next_ls.state   = L_WDAT;
            end
            else
            begin
              next_ls.wr_addr   = ls.pointer;
              next_ls.wr_data   = rx_byte;
              next_ls.wr_toggle = !ls.wr_toggle;
              next_ls.pointer   = ls.pointer + 8'h01;
            end
          end
        end
        L_RDAT:
        begin
          next_ls.ack   = 1'b0;
          next_ls.drive = 1'b1;
          if (!ls.drive)
            next_ls.bit_cnt = 4'd0;
          else if (ls.bit_cnt < 4'd7)
          begin
            next_ls.shift   = {ls.shift[6:0], 1'b0};
            next_ls.bit_cnt = ls.bit_cnt + 4'd1;
          end
          else
          begin
            next_ls.bit_cnt = 4'd0;
            next_ls.drive   = 1'b0;
            next_ls.state   = L_RACK;
            next_ls.pointer = (ls.pointer == dwr_pkg::PTR_WRAP) ?
                              8'h00 : ls.pointer + 8'h01;
          end
        end
        L_RACK:
        begin
          next_ls.state   = SDA_IN ? L_IDLE : L_RDAT;
          next_ls.drive   = !SDA_IN;
          next_ls.bit_cnt = 4'd0;
          next_ls.shift   = rd_value;
        end
        default:
          next_ls.state = L_IDLE;
      endcase
    end
    if (RESET)
      next_ls = '{state: L_IDLE, default: '0};
  end

  always_ff @(posedge SCL)
  begin
    ls <= next_ls;
  end

  // output bit moves only after the falling edge
  always_comb
  begin
    next_fs.sda_low = 1'b0;
    if (ls.ack)
      next_fs.sda_low = 1'b1;
    else if (ls.drive)
      next_fs.sda_low = !ls.shift[7];
    if (RESET)
      next_fs.sda_low = 1'b0;
  end

  always_ff @(negedge SCL)
  begin
    fs <= next_fs;
  end

  assign SDA_OUT  = 1'b0;
  assign SDA_OE_N = !fs.sda_low;

  // ------------------------------------------------------------------
  // core side (CLOCK domain): registers, power-up, program timer
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    P_FORCE = 3'b001,
    P_LOAD  = 3'b010,
    P_RUN   = 3'b100
  } dwr_pwr_type;

  typedef struct packed {
    dwr_pwr_type                  pwr;
    logic [15:0]                  pwr_cnt;
    logic [1:0][7:0]              wiper;
    logic [1:0][7:0]              store;
    logic [1:0][7:0]              nv_cell;
    logic                         vol_sel;
    logic                         shdn;
    logic                         pending;
    logic                         armed;
    logic [31:0]                  nv_cnt;
    logic [2:0]                   wr_sync;
    logic [2:0]                   stop_sync;
    logic [2:0]                   strap_h;
    logic [2:0]                   strap_l;
    logic [7:0]                   rd_image;
  } dwr_core_type;

  dwr_core_type cs;
  dwr_core_type next_cs;

  function automatic logic [7:0] read_reg(input dwr_core_type c,
                                          input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == dwr_pkg::REG_POS0 || a == dwr_pkg::REG_POS1)
      v = c.vol_sel ? c.wiper[a[0]] : c.store[a[0]];
    else if (a == dwr_pkg::REG_ACCESS)
    begin
      v[dwr_pkg::ACC_VOLATILE_BIT] = c.vol_sel;
      v[dwr_pkg::ACC_SHDN_BIT]     = c.shdn;
      v[dwr_pkg::ACC_PENDING_BIT]  = c.pending;
    end
    return v;
  endfunction

  always_comb
  begin
    next_cs           = cs;
    next_cs.wr_sync   = {cs.wr_sync[1:0], ls.wr_toggle};
    next_cs.stop_sync = {cs.stop_sync[1:0], stop_toggle};
    next_cs.strap_h   = {cs.strap_h[1:0], ADDR_STRAP_HIGH};
    next_cs.strap_l   = {cs.strap_l[1:0], ADDR_STRAP_LOW};
    next_cs.rd_image  = read_reg(cs, ls.pointer);
    unique case (cs.pwr)
      P_FORCE:
      begin
        next_cs.wiper   = {dwr_pkg::WIPER_RESET, dwr_pkg::WIPER_RESET};
        next_cs.pwr_cnt = cs.pwr_cnt + 16'd1;
        if (cs.pwr_cnt == 16'(dwr_pkg::POWERUP_CYCLES))
          next_cs.pwr = P_LOAD;
      end
      P_LOAD:
      begin
        next_cs.store = cs.nv_cell;
        next_cs.wiper = cs.nv_cell;
        next_cs.pwr   = P_RUN;
      end
      P_RUN:
      begin
        if (cs.wr_sync[2] != cs.wr_sync[1])
        begin
          if (ls.wr_addr == dwr_pkg::REG_POS0 || ls.wr_addr == dwr_pkg::REG_POS1)
          begin
            if (!cs.vol_sel)
            begin
              if (!cs.pending)
              begin
                next_cs.store[ls.wr_addr[0]] = ls.wr_data;
                next_cs.wiper[ls.wr_addr[0]] = ls.wr_data;
                next_cs.armed = 1'b1;
              end
            end
            else if (!cs.pending)
              next_cs.wiper[ls.wr_addr[0]] = ls.wr_data;
          end
          else if (ls.wr_addr == dwr_pkg::REG_ACCESS && !cs.pending)
          begin
            next_cs.vol_sel = ls.wr_data[dwr_pkg::ACC_VOLATILE_BIT];
            next_cs.shdn    = ls.wr_data[dwr_pkg::ACC_SHDN_BIT];
          end
        end
        if (cs.stop_sync[2] != cs.stop_sync[1] && cs.armed)
        begin
          next_cs.pending = 1'b1;
          next_cs.armed   = 1'b0;
          next_cs.nv_cnt  = '0;
        end
        else if (cs.pending)
        begin
          next_cs.nv_cnt = cs.nv_cnt + 32'd1;
          if (cs.nv_cnt == 32'(NV_CYCLES - 1))
          begin
            next_cs.pending = 1'b0;
            next_cs.nv_cell = cs.store;
          end
        end
      end
      default:
        next_cs.pwr = P_FORCE;
    endcase
    if (RESET)
    begin
      next_cs         = '0;
      next_cs.pwr     = P_FORCE;
      next_cs.nv_cell = cs.nv_cell;
      next_cs.wiper   = {dwr_pkg::WIPER_RESET, dwr_pkg::WIPER_RESET};
      next_cs.vol_sel = dwr_pkg::ACC_VOLATILE_RST;
      next_cs.shdn    = dwr_pkg::ACC_SHDN_RST;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    cs <= next_cs;
  end

  assign sync_strap_high = cs.strap_h[2];
  assign sync_strap_low  = cs.strap_l[2];
  assign rd_value        = cs.rd_image;

  // ------------------------------------------------------------------
  // outputs and tap switches
  // ------------------------------------------------------------------
  assign WIPER_POSITION_0 = cs.wiper[0];
  assign WIPER_POSITION_1 = cs.wiper[1];
  assign SHUTDOWN_N       = cs.shdn;
  assign NV_WRITE_PENDING = cs.pending;

  dwr_tap_switch #(
    .TAPS       (dwr_pkg::TAPS)
  ) u_sw0 (
    .clock      (CLOCK),
    .reset      (RESET),
    .code       (cs.wiper[0]),
    .tap_closed (TAP_CLOSED_0)
  );

  dwr_tap_switch #(
    .TAPS       (dwr_pkg::TAPS)
  ) u_sw1 (
    .clock      (CLOCK),
    .reset      (RESET),
    .code       (cs.wiper[1]),
    .tap_closed (TAP_CLOSED_1)
  );
endmodule
`default_nettype wire

// File: bench/dwr_props.sv
`default_nettype none
module dwr_props #(
  parameter int unsigned NV_CYCLES = 600
) (
  input wire logic         CLOCK,
  input wire logic         RESET,
  input wire logic         SCL,
  input wire logic         SDA_IN,
  input wire logic         SDA_OUT,
  input wire logic         SDA_OE_N,
  input wire logic [7:0]   WIPER_POSITION_0,
  input wire logic [7:0]   WIPER_POSITION_1,
  input wire logic [255:0] TAP_CLOSED_0,
  input wire logic [255:0] TAP_CLOSED_1,
  input wire logic         NV_WRITE_PENDING
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  logic [31:0] busy;
  // length of the running program cycle
  always_ff @(posedge CLOCK)
  begin
    busy <= NV_WRITE_PENDING ? busy + 32'h1 : 32'h0;
  end
  a_drain_only: assert property (SDA_OUT == 1'b0)
    else $error("sda output driven high");
  a_oe_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL)
    else $error("sda enable moved while scl high");
  a_tap_map0: assert property (
    $stable(WIPER_POSITION_0) [*6] |->
    TAP_CLOSED_0 == (256'h1 << WIPER_POSITION_0))
    else $error("tap 0 does not follow code");
  a_tap_map1: assert property (
    $stable(WIPER_POSITION_1) [*6] |->
    TAP_CLOSED_1 == (256'h1 << WIPER_POSITION_1))
    else $error("tap 1 does not follow code");
  a_make_break: assert property (
    |($past(TAP_CLOSED_0) & ~TAP_CLOSED_0) |->
    |(TAP_CLOSED_0 & $past(TAP_CLOSED_0)))
    else $error("old tap opened before new closed");
  a_reset_mid: assert property ($fell(RESET) |->
    (WIPER_POSITION_0 == 8'h80 && WIPER_POSITION_1 == 8'h80) [*8])
    else $error("wiper not mid-scale after reset");
  a_pend_bound: assert property (busy <= NV_CYCLES + 32'd16)
    else $error("program cycle too long");
  a_pend_freeze: assert property (
    NV_WRITE_PENDING && $past(NV_WRITE_PENDING, 8) |->
    $stable(WIPER_POSITION_0) && $stable(WIPER_POSITION_1))
    else $error("wiper moved during program cycle");
  a_pend_start: assert property (
    $rose(NV_WRITE_PENDING) |-> SCL && SDA_IN)
    else $error("program cycle began outside stop");
endmodule
bind dwr_wiper_ctrl dwr_props #(.NV_CYCLES(NV_CYCLES)) u_props (
  .CLOCK(CLOCK), .RESET(RESET), .SCL(SCL), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .WIPER_POSITION_0(WIPER_POSITION_0),
  .WIPER_POSITION_1(WIPER_POSITION_1),
  .TAP_CLOSED_0(TAP_CLOSED_0), .TAP_CLOSED_1(TAP_CLOSED_1),
  .NV_WRITE_PENDING(NV_WRITE_PENDING));
`default_nettype wire

// File: bench/dwr_i2c_master.sv
`default_nettype none
module dwr_i2c_master (
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // scl idles high between frames; each step is one 30 ns period
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // also serves as repeated start from scl low
  task automatic start();
    #4.3 sda_low = 1'b0;
    #11.4 scl = 1'b1;
    #7.9 sda_low = 1'b1;
    #6.4 scl = 1'b0;
  endtask
  task automatic stop();
    #4.3 sda_low = 1'b1;
    #11.4 scl = 1'b1;
    #7.9 sda_low = 1'b0;
    #6.4;
  endtask
  // eight bits msb first, then the ack slot
  task automatic xfer(input logic [7:0] wb, input logic ab,
                      output logic [7:0] rb, output logic ack);
    logic [8:0] w;
    logic [8:0] r;
    w = {wb, ab};
    for (int i = 8; i >= 0; i--)
    begin
      #4.3 sda_low = !w[i];
      #11.4 scl = 1'b1;
      #7.9 r[i] = sda;
      #6.4 scl = 1'b0;
    end
    {rb, ack} = r;
  endtask
endmodule
`default_nettype wire

// File: bench/dual_wiper_register_control_tb_top.sv
`default_nettype none
module dual_wiper_register_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned NV  = 600;
  localparam logic [4:0]  IDP = 5'h13; // arbitrary identity prefix
  typedef struct packed { logic [7:0] a; logic [7:0] d; } dwr_row_type;
  logic         CLOCK = 1'b0;
  logic         RESET = 1'b1;
  logic [1:0]   strap = 2'h0;
  logic         scl, sda_low, sda_out, sda_oe_n, pend, shdn, ok;
  logic [7:0]   w0, w1, v, e;
  logic [255:0] t0, t1;
  int           err_count = 0;
  int           check_count = 0;
  wire logic    sda = !sda_low && (sda_oe_n || sda_out);
  dwr_row_type  rows [8] = '{'{8'h10, 8'hc0}, '{8'h00, 8'h00},
    '{8'h01, 8'hff}, '{8'h00, 8'hff}, '{8'h01, 8'h00},
    '{8'h00, 8'h80}, '{8'h10, 8'h80}, '{8'h10, 8'hc0}};
  always #5 CLOCK = !CLOCK;
  dwr_wiper_ctrl #(.NV_CYCLES(NV), .ID_PREFIX(IDP)) dut (
    .CLOCK(CLOCK), .RESET(RESET), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
    .ADDR_STRAP_HIGH(strap[1]), .ADDR_STRAP_LOW(strap[0]),
    .WIPER_POSITION_0(w0), .WIPER_POSITION_1(w1),
    .TAP_CLOSED_0(t0), .TAP_CLOSED_1(t1),
    .SHUTDOWN_N(shdn), .NV_WRITE_PENDING(pend));
  dwr_i2c_master m (.sda(sda), .scl(scl), .sda_low(sda_low));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] x, g);
    check_count++;
    if (g !== x)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_tap(input string n, input logic [7:0] c,
                         input logic [255:0] g);
    check_count++;
    if (g !== (256'h1 << c))
    begin
      err_count++;
      $display("mismatch %s expected tap %0d seen %h", n, c, g);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] a, d);
    logic [7:0] r;
    logic       k0, k1, k2;
    m.start();
    m.xfer({IDP, s, 1'b0}, 1'b1, r, k0);
    m.xfer(a, 1'b1, r, k1);
    m.xfer(d, 1'b1, r, k2);
    m.stop();
    ok = !(k0 | k1 | k2);
    repeat (10) @(negedge CLOCK);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] r;
    logic       k;
    m.start();
    m.xfer({IDP, strap, 1'b0}, 1'b1, r, k);
    m.xfer(a, 1'b1, r, k);
    m.start();
    m.xfer({IDP, strap, 1'b1}, 1'b1, r, k);
    m.xfer(8'hff, 1'b1, v, k);
    m.stop();
    repeat (4) @(negedge CLOCK);
  endtask
  task automatic do_reset();
    RESET = 1'b1;
    fork
      m.start();
      repeat (4) @(negedge CLOCK);
    join
    m.stop();
    @(negedge CLOCK);
    RESET = 1'b0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < NV + 40 && pend === 1'b1; i++)
      @(negedge CLOCK);
    chk("pending", 8'h00, {7'h0, pend});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    #200us;
    err_count++;
    wrap_up();
  end
  initial
  begin
    do_reset();
    repeat (30) @(negedge CLOCK);
    rd(8'h10);
    chk("control", 8'h40, v);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(strap, rows[i].a, rows[i].d);
      chk("ack", 8'h01, {7'h0, ok});
      rd(rows[i].a);
      chk("readback", rows[i].d, v);
      if (rows[i].a == 8'h10)
        chk("shutdown", {7'h0, rows[i].d[6]}, {7'h0, shdn});
      else
      begin
        chk("wiper", rows[i].d, rows[i].a[0] ? w1 : w0);
        chk_tap("tap", rows[i].d, rows[i].a[0] ? t1 : t0);
      end
    end
    $display("test rows done");
    e = 8'h80;
    for (int s = 0; s < 4; s++)
    begin
      strap = s[1:0];
      repeat (5) @(negedge CLOCK);
      wr(strap ^ (s[0] ? 2'h1 : 2'h2), 8'h00, 8'h11);
      chk("stray ack", 8'h00, {7'h0, ok});
      chk("wiper0", e, w0);
      e = 8'h20 + s[7:0];
      wr(strap, 8'h00, e);
      chk("wiper0", e, w0);
    end
    $display("test straps done");
    wr(strap, 8'h10, 8'h40);
    wr(strap, 8'h00, 8'h5a);
    chk("wiper0", 8'h5a, w0);
    chk("pending", 8'h01, {7'h0, pend});
    wr(strap, 8'h01, 8'h77);
    chk("wiper1", 8'h00, w1);
    rd(8'h10);
    chk("control", 8'h60, v);
    wr(strap, 8'h10, 8'hc0);
    wait_idle();
    rd(8'h10);
    chk("control", 8'h40, v);
    wr(strap, 8'h01, 8'ha5);
    chk("wiper1", 8'ha5, w1);
    wait_idle();
    $display("test store done");
    do_reset();
    chk("wiper0", 8'h80, w0);
    chk("wiper1", 8'h80, w1);
    repeat (30) @(negedge CLOCK);
    chk("wiper0", 8'h5a, w0);
    chk("wiper1", 8'ha5, w1);
    rd(8'h10);
    chk("control", 8'h40, v);
    $display("test reload done");
    wrap_up();
  end
endmodule
`default_nettype wire
